// *** rse_map.svh ***
// Overview of operation
// - Flag address miss on last received packet
// - Flag strength sample finished, value available
// - Flag bit counter reaching compare value
// - Compare value comes from software register
// - Flag packet received with CRC pass
// - Flag packet received with CRC fail
// - Flag address match on last received packet
`ifndef RSE_MAP_SVH
`define RSE_MAP_SVH
`define RSE_OFF_ADDR_MATCH 12'h114
`define RSE_OFF_ADDR_MISS 12'h118
`define RSE_OFF_SAMPLE_DONE 12'h11C
`define RSE_OFF_BC_MATCH 12'h128
`define RSE_OFF_CRC_PASS 12'h130
`define RSE_OFF_CRC_FAIL 12'h134
`define RSE_OFF_BC_COMPARE 12'h140
`define RSE_OFF_SAMPLE_VALUE 12'h144
`define RSE_OFF_BC_CONTROL 12'h148
`define RSE_OFF_BC_VALUE 12'h14C
`define RSE_FLAG_BIT 0
`define RSE_EVENT_RESET 1'b0
`define RSE_BCC_RESET 32'h00000000
`define RSE_NUM_EVENTS 6
`endif

// *** rse_pkg.sv ***
package rse_pkg;
	typedef enum logic [5:0] {
		RSE_EV_ADDR_MATCH = 6'h01,
		RSE_EV_ADDR_MISS = 6'h02,
		RSE_EV_SAMPLE_DONE = 6'h04,
		RSE_EV_BC_MATCH = 6'h08,
		RSE_EV_CRC_PASS = 6'h10,
		RSE_EV_CRC_FAIL = 6'h20
	} rse_event_t;
	typedef enum logic [1:0] {
		RSE_BC_IDLE = 2'b01,
		RSE_BC_RUN = 2'b10
	} rse_bc_state_t;
endpackage

// *** rse_ev_if.sv ***
`timescale 1ns/100ps
interface rse_ev_if #(parameter int N = 6);
	logic [N-1:0] set;
	logic [N-1:0] clr;
	logic [N-1:0] flags;
	modport owner (input set, input clr, output flags);
	modport user (output set, output clr, input flags);
endinterface // rse_ev_if

// *** rse_flags.sv ***
`timescale 1ns/100ps
`include "rse_map.svh"
module rse_flags
	import rse_pkg::*;
#(
	parameter int N = `RSE_NUM_EVENTS
) (
	input wire logic clk,
	input wire logic rstn,
	rse_ev_if.owner ev
);
	// Refused at elaboration, not at run time
	if (N < 1) begin : g_bad_n
		$error("rse_flags needs at least one event");
	end
	for (genvar i = 0; i < N; i++) begin : g_flag
		logic flag_q;
		// Set wins over a clear in the same cycle
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				flag_q <= `RSE_EVENT_RESET;
			end else if (ev.set[i]) begin
				flag_q <= 1'b1;
			end else if (ev.clr[i]) begin
				flag_q <= 1'b0;
			end
		end
		assign ev.flags[i] = flag_q;
	end
endmodule // rse_flags

// *** rse_bit_counter.sv ***
`timescale 1ns/100ps
`include "rse_map.svh"
module rse_bit_counter
	import rse_pkg::*;
#(
	parameter int W = 32
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic start,
	input wire logic stop,
	input wire logic bit_tick,
	input wire logic [W-1:0] compare,
	output logic [W-1:0] count,
	output logic match
);
	if (W < 1 || W > 32) begin : g_bad_w
		$error("rse_bit_counter width out of range");
	end
	rse_bc_state_t state_q;
	logic [W-1:0] count_q;
	logic hit;
	assign hit = (state_q == RSE_BC_RUN) && bit_tick && (count_q + 1'b1 == compare);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= RSE_BC_IDLE;
		end else if (stop) begin
			state_q <= RSE_BC_IDLE;
		end else if (start) begin
			state_q <= RSE_BC_RUN;
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count_q <= '0;
		end else if (start) begin
			count_q <= '0;
		end else if (state_q == RSE_BC_RUN && bit_tick) begin
			count_q <= count_q + 1'b1;
		end
	end
	// Match pulses once as the count steps onto the compare value
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			match <= 1'b0;
		end else begin
			match <= hit;
		end
	end
	assign count = count_q;
endmodule // rse_bit_counter

// *** rse_radio_events.sv ***
// The APB register port is this design's own decision.
`timescale 1ns/100ps
`include "rse_map.svh"
module rse_radio_events
	import rse_pkg::*;
#(
	parameter int SAMPLE_W = 7
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pkt_done,
	input wire logic addr_matched,
	input wire logic crc_ok,
	input wire logic sample_done,
	input wire logic [SAMPLE_W-1:0] sample_value,
	input wire logic bit_tick,
	input wire logic bc_start,
	input wire logic bc_stop
);
	if (SAMPLE_W < 1 || SAMPLE_W > 32) begin : g_bad_sample_w
		$error("sample width out of range");
	end
	localparam int N = `RSE_NUM_EVENTS;
	rse_ev_if #(.N(N)) ev ();
	logic [31:0] bcc_q;
	logic [SAMPLE_W-1:0] sample_q;
	logic [31:0] bc_count;
	logic bc_match;
	logic wr_en;
	logic rd_en;
	logic hit;
	logic [31:0] rdata_d;
	logic [N-1:0] ev_sel;

	// Maps an offset onto the one-hot event it names
	function automatic logic [N-1:0] ev_decode(input logic [11:0] a);
		unique case (a)
			`RSE_OFF_ADDR_MATCH: ev_decode = RSE_EV_ADDR_MATCH;
			`RSE_OFF_ADDR_MISS: ev_decode = RSE_EV_ADDR_MISS;
			`RSE_OFF_SAMPLE_DONE: ev_decode = RSE_EV_SAMPLE_DONE;
			`RSE_OFF_BC_MATCH: ev_decode = RSE_EV_BC_MATCH;
			`RSE_OFF_CRC_PASS: ev_decode = RSE_EV_CRC_PASS;
			`RSE_OFF_CRC_FAIL: ev_decode = RSE_EV_CRC_FAIL;
			default: ev_decode = '0;
		endcase
	endfunction

	assign ev_sel = ev_decode(paddr);
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign hit = (|ev_sel) || paddr == `RSE_OFF_BC_COMPARE || paddr == `RSE_OFF_SAMPLE_VALUE
		|| paddr == `RSE_OFF_BC_VALUE;
	// Unmapped addresses answer with an error, reads return zero
	assign pslverr = psel && penable && !hit;

	// Radio outcomes become flag set strobes
	always_comb begin
		ev.set = '0;
		ev.set[0] = pkt_done && addr_matched;
		ev.set[1] = pkt_done && !addr_matched;
		ev.set[2] = sample_done;
		ev.set[3] = bc_match;
		ev.set[4] = pkt_done && crc_ok;
		ev.set[5] = pkt_done && !crc_ok;
	end
	// Only writing zero clears; writing one leaves a flag as it is
	assign ev.clr = (wr_en && !pwdata[`RSE_FLAG_BIT]) ? ev_sel : '0;

	rse_flags #(.N(N)) u_flags (
		.clk(clk),
		.rstn(rstn),
		.ev(ev.owner)
	);

	rse_bit_counter #(.W(32)) u_bc (
		.clk(clk),
		.rstn(rstn),
		.start(bc_start),
		.stop(bc_stop),
		.bit_tick(bit_tick),
		.compare(bcc_q),
		.count(bc_count),
		.match(bc_match)
	);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bcc_q <= `RSE_BCC_RESET;
		end else if (wr_en && paddr == `RSE_OFF_BC_COMPARE) begin
			bcc_q <= pwdata;
		end
	end

	// Sample held so software reads a stable value after the flag
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sample_q <= '0;
		end else if (sample_done) begin
			sample_q <= sample_value;
		end
	end

	always_comb begin
		rdata_d = 32'h00000000;
		if (|ev_sel) begin
			rdata_d[`RSE_FLAG_BIT] = |(ev.flags & ev_sel);
		end else if (paddr == `RSE_OFF_BC_COMPARE) begin
			rdata_d = bcc_q;
		end else if (paddr == `RSE_OFF_SAMPLE_VALUE) begin
			rdata_d[SAMPLE_W-1:0] = sample_q;
		end else if (paddr == `RSE_OFF_BC_VALUE) begin
			rdata_d = bc_count;
		end
	end

	// Read data registered in setup so it stands in the access phase
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rdata_d;
		end
	end
endmodule // rse_radio_events

// *** rse_radio_events_properties.sv ***
`timescale 1ns/100ps
module rse_radio_events_properties (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pkt_done,
	input wire logic addr_matched,
	input wire logic crc_ok,
	input wire logic sample_done
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// Read data loads at the setup edge, so the flag must be set one edge after its cause
	sequence rd(a);
		psel && !penable && !pwrite && paddr == a;
	endsequence
	property p_flag(ev, a);
		ev ##1 rd(a) |=> prdata == 32'h1;
	endproperty
	a_miss_flag:
		assert property (p_flag(pkt_done && !addr_matched, 12'h118)) else $error("miss flag");
	a_sample_flag:
		assert property (p_flag(sample_done, 12'h11C)) else $error("sample flag");
	a_pass_flag:
		assert property (p_flag(pkt_done && crc_ok, 12'h130)) else $error("pass flag");
	a_fail_flag:
		assert property (p_flag(pkt_done && !crc_ok, 12'h134)) else $error("fail flag");
	a_match_flag:
		assert property (p_flag(pkt_done && addr_matched, 12'h114)) else $error("match flag");
	a_zero_clears:
		assert property (psel && penable && pwrite && paddr == 12'h130 && pwdata == 32'h0
			&& !pkt_done ##1 !pkt_done ##1 rd(12'h130) |=> prdata == 32'h0)
		else $error("clear failed");
	a_upper_zero:
		assert property (psel && penable && !pwrite && paddr inside {12'h114, 12'h118, 12'h11C,
			12'h128, 12'h130, 12'h134} |-> prdata[31:1] == 31'h0) else $error("upper bits");
	a_ready_high:
		assert property (pready) else $error("wait state");
endmodule // rse_radio_events_properties
bind rse_radio_events rse_radio_events_properties chk (
	.clk(clk),
	.rstn(rstn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.prdata(prdata),
	.pready(pready),
	.pkt_done(pkt_done),
	.addr_matched(addr_matched),
	.crc_ok(crc_ok),
	.sample_done(sample_done)
);

// *** rse_radio_events_tb.sv ***
`timescale 1ns/100ps
module rse_radio_events_tb;
	logic clk, rstn, psel, penable, pwrite, pready, pslverr, rslverr;
	logic pkt_done, addr_matched, crc_ok, sample_done, bit_tick, bc_start, bc_stop;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic [6:0] sample_value;
	logic [11:0] offs [6] = '{12'h114, 12'h118, 12'h11C, 12'h128, 12'h130, 12'h134};
	int num_errors = 0;
	int num_checks = 0;
	rse_radio_events uut (
		.clk(clk),
		.rstn(rstn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.pkt_done(pkt_done),
		.addr_matched(addr_matched),
		.crc_ok(crc_ok),
		.sample_done(sample_done),
		.sample_value(sample_value),
		.bit_tick(bit_tick),
		.bc_start(bc_start),
		.bc_stop(bc_stop)
	);
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	task chk(string n, logic [31:0] s, logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	// Ends one idle edge after the access so the next call never reassigns in the same step
	task acc(logic w, logic [11:0] a, logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk) penable <= 1'h1;
		@(posedge clk) while (pready !== 1'h1) @(posedge clk);
		rdata = prdata;
		rslverr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask
	task rd(logic [11:0] a, logic [31:0] e);
		acc(1'h0, a, 32'h0);
		chk($sformatf("reg %h", a), rdata, e);
	endtask
	task ev(logic [3:0] v);
		{pkt_done, addr_matched, crc_ok, sample_done} <= v;
		@(posedge clk) {pkt_done, addr_matched, crc_ok, sample_done} <= 4'h0;
	endtask
	task finish_test;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (2000) @(posedge clk);
		num_errors++;
		finish_test;
	end
	initial begin
		rstn = 1'h0;
		{psel, penable, pwrite, pkt_done, addr_matched, crc_ok, sample_done} = '0;
		{bit_tick, bc_start, bc_stop, paddr, pwdata, sample_value} = '0;
		repeat (10) @(posedge clk);
		rstn <= 1'h1;
		@(posedge clk);
		foreach (offs[i]) rd(offs[i], 32'h0);
		ev(4'hA);
		rd(12'h118, 32'h1);
		rd(12'h114, 32'h0);
		ev(4'hA);
		rd(12'h130, 32'h1);
		chk("slverr 130", {31'h0, rslverr}, 32'h0);
		rd(12'h134, 32'h0);
		ev(4'hC);
		rd(12'h114, 32'h1);
		ev(4'hC);
		rd(12'h134, 32'h1);
		sample_value <= 7'h5A;
		ev(4'h1);
		rd(12'h11C, 32'h1);
		rd(12'h144, 32'h5A);
		acc(1'h1, 12'h130, 32'h1);
		rd(12'h130, 32'h1);
		acc(1'h1, 12'h130, 32'h0);
		rd(12'h130, 32'h0);
		// Clear and packet outcome in one access cycle: the set must win
		fork
			acc(1'h1, 12'h130, 32'h0);
			begin
				@(posedge clk);
				ev(4'hA);
			end
		join
		rd(12'h130, 32'h1);
		rd(12'h148, 32'h0);
		chk("slverr 148", {31'h0, rslverr}, 32'h1);
		acc(1'h1, 12'h140, 32'h3);
		rd(12'h140, 32'h3);
		bc_start <= 1'h1;
		@(posedge clk) bc_start <= 1'h0;
		// Match is registered twice, hence the two idle edges
		for (int i = 1; i <= 3; i++) begin
			bit_tick <= 1'h1;
			@(posedge clk) bit_tick <= 1'h0;
			repeat (2) @(posedge clk);
			rd(12'h128, {31'h0, i == 3});
		end
		rd(12'h14C, 32'h3);
		// A stopped counter ignores further bit ticks
		bc_stop <= 1'h1;
		@(posedge clk) bc_stop <= 1'h0;
		bit_tick <= 1'h1;
		@(posedge clk) bit_tick <= 1'h0;
		@(posedge clk);
		rd(12'h14C, 32'h3);
		// Reset in mid-run with every flag set
		rstn <= 1'h0;
		repeat (2) @(posedge clk);
		rstn <= 1'h1;
		@(posedge clk);
		foreach (offs[i]) rd(offs[i], 32'h0);
		rd(12'h140, 32'h0);
		finish_test;
	end
endmodule // rse_radio_events_tb
